// File: rtl/floppy_rate_and_result_status.sv
`timescale 1ns/1ps
`default_nettype none

module floppy_rate_and_result_status #(
  parameter int step_count  = fdc_rate_pkg::recal_steps,
  parameter int index_count = fdc_rate_pkg::index_limit
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      soft_reset,
  // host i/o, strobes are one-cycle pulses on clk
  input  wire logic [9:0]                io_addr,
  input  wire logic                      io_rd,
  input  wire logic                      io_wr,
  input  wire logic [7:0]                io_wdata,
  output logic [7:0]                     io_rdata,
  output logic [7:0]                     io_rdata_oe,
  output logic                           io_rvalid,
  // configuration bits
  input  wire logic                      cfg_ident,
  input  wire logic                      cfg_mfm,
  input  wire logic                      force_chg_en,
  input  wire logic                      force_chg_val,
  input  wire logic                      dma_gate,
  // sequencer side
  input  wire logic                      result_phase,
  input  wire fdc_rate_pkg::seq_event_s  seq_ev,
  input  wire fdc_rate_pkg::seq_ctx_s    seq_ctx,
  // drive cable pins, asynchronous
  input  wire logic                      disk_changed_pin,
  input  wire logic                      track_zero_pin,
  input  wire logic                      index_pin,
  input  wire logic                      write_protect_pin,
  // drive outputs and state
  output logic                           density_select,
  output logic [1:0]                     rate_sel,
  output logic                           precomp_off
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_reg;  // first stage, read only by second stage
  logic [3:0] pin_sync_reg;  // safe copies of the cable pins
  logic       index_last_reg; // previous index level for edge detect

  // two flops per pin; the cable is fully asynchronous to clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {write_protect_pin, index_pin,
                       track_zero_pin, disk_changed_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic chg_sync;   // disk change level from cable
  logic track_zero_pin_sync;  // track zero active
  logic idx_sync;   // index level
  logic wp_sync;    // write protect active
  assign {wp_sync, idx_sync, track_zero_pin_sync, chg_sync} = pin_sync_reg;

  // index edge from the synchronised copy only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_last_reg <= 1'b0;
    end else begin
      index_last_reg <= idx_sync;
    end
  end

  logic index_rise;
  assign index_rise = idx_sync & ~index_last_reg;

  // ----------------------------------------------------------------
  // register mode decode
  // ----------------------------------------------------------------
  fdc_rate_pkg::reg_mode_e mode;

  always_comb begin
    if (cfg_ident) begin
      mode = fdc_rate_pkg::mode_std;
    end else if (cfg_mfm) begin
      mode = fdc_rate_pkg::mode_bidir;
    end else begin
      mode = fdc_rate_pkg::mode_compact;
    end
  end

  // high density when rate is 500k or 1m
  function automatic logic high_rate(input logic [1:0] r);
    high_rate = (r == fdc_rate_pkg::rate_500k) ||
                (r == fdc_rate_pkg::rate_1m);
  endfunction

  // set wins over a same-cycle clear, shared by every status flag
  function automatic logic flag_next(input logic cur_val, input logic set_ev, input logic clr_ev);
    flag_next = set_ev || (cur_val && !clr_ev);
  endfunction

  // ----------------------------------------------------------------
  // rate control write, address shared with the input register
  // ----------------------------------------------------------------
  logic wr_rate;
  assign wr_rate = io_wr && (io_addr == fdc_rate_pkg::addr_input);

  // soft reset deliberately not in the sensitivity or the branches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_sel <= fdc_rate_pkg::rate_250k;
    end else if (wr_rate) begin
      // upper bits are expected zero and simply ignored
      rate_sel <= io_wdata[1:0];
    end
  end

  // stored only in compact mode, no effect besides read back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      precomp_off <= 1'b0;
    end else if (wr_rate && mode == fdc_rate_pkg::mode_compact) begin
      precomp_off <= io_wdata[fdc_rate_pkg::bit_precomp];
    end
  end

  // density pin follows the rate written; polarity per mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      density_select <= fdc_rate_pkg::density_rst;
    end else if (wr_rate) begin
      if (mode == fdc_rate_pkg::mode_std) begin
        density_select <= high_rate(io_wdata[1:0]);
      end else begin
        density_select <= ~high_rate(io_wdata[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // status accumulation during a command
  // ----------------------------------------------------------------
  logic [1:0] intr_code_reg;        // completion code
  logic       positioning_done_reg; // seek end
  logic       equipment_fault_reg;  // track zero or outward fault
  logic       past_last_sector_reg;
  logic       crc_fault_reg;
  logic       lost_service_reg;
  logic       sector_missing_reg;
  logic       write_blocked_reg;
  logic       addr_sync_lost_reg;
  logic [6:0] step_cnt_reg;         // steps during recalibrate
  logic [1:0] index_cnt_reg;        // index pulses during id search

  // completion code latched when the command ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intr_code_reg <= 2'h0;
    end else if (soft_reset) begin
      intr_code_reg <= 2'h0;
    end else if (seq_ev.cmd_done) begin
      intr_code_reg <= seq_ev.intr_code;
    end
  end

  logic clr_flags; // command start or soft reset
  assign clr_flags = soft_reset || seq_ev.cmd_start;

  // seek end; a same-cycle set wins over the start clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      positioning_done_reg <= 1'b0;
    end else begin
      positioning_done_reg <= flag_next(positioning_done_reg, seq_ev.seek_done, clr_flags);
    end
  end

  // recalibrate step counter, saturates at the limit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_cnt_reg <= 7'h00;
    end else if (soft_reset || !seq_ctx.recal_active) begin
      step_cnt_reg <= 7'h00;
    end else if (seq_ev.step && step_cnt_reg < 7'(step_count)) begin
      step_cnt_reg <= step_cnt_reg + 7'h01;
    end
  end

  logic recal_fail;
  assign recal_fail = seq_ctx.recal_active && !track_zero_pin_sync &&
                      (step_cnt_reg == 7'(step_count));

  // equipment fault, set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      equipment_fault_reg <= 1'b0;
    end else begin
      equipment_fault_reg <= flag_next(equipment_fault_reg, recal_fail || seq_ev.outward_past0, clr_flags);
    end
  end

  // index pulse counter while looking for an id mark
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_cnt_reg <= 2'h0;
    end else if (soft_reset || !seq_ctx.id_search) begin
      index_cnt_reg <= 2'h0;
    end else if (index_rise && index_cnt_reg < 2'(index_count)) begin
      index_cnt_reg <= index_cnt_reg + 2'h1;
    end
  end

  logic sync_lost;
  assign sync_lost = (seq_ctx.id_search &&
                      index_cnt_reg == 2'(index_count)) ||
                     seq_ev.no_data_mark;

  // second status byte flags; events set, command start clears;
  // the protect pin counts only while a writing command runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {past_last_sector_reg, crc_fault_reg, lost_service_reg,
       sector_missing_reg, write_blocked_reg, addr_sync_lost_reg} <= 6'h00;
    end else begin
      past_last_sector_reg <= flag_next(past_last_sector_reg, seq_ev.sector_over, clr_flags);
      crc_fault_reg        <= flag_next(crc_fault_reg, seq_ev.crc_bad, clr_flags);
      lost_service_reg     <= flag_next(lost_service_reg, seq_ev.service_late, clr_flags);
      sector_missing_reg   <= flag_next(sector_missing_reg, seq_ev.no_sector, clr_flags);
      write_blocked_reg    <= flag_next(write_blocked_reg, seq_ctx.write_active && wp_sync, clr_flags);
      addr_sync_lost_reg   <= flag_next(addr_sync_lost_reg, sync_lost, clr_flags);
    end
  end

  // assembled status bytes; head and unit are live values
  logic [7:0] status0;
  logic [7:0] status1;
  assign status0 = {intr_code_reg, positioning_done_reg,
                    equipment_fault_reg, 1'b0,
                    seq_ctx.side_number, seq_ctx.unit_select};
  assign status1 = {past_last_sector_reg, 1'b0, crc_fault_reg,
                    lost_service_reg, 1'b0, sector_missing_reg,
                    write_blocked_reg, addr_sync_lost_reg};

  // ----------------------------------------------------------------
  // result byte pointer
  // ----------------------------------------------------------------
  fdc_rate_pkg::res_state_e res_reg;
  logic rd_data;
  assign rd_data = io_rd && (io_addr == fdc_rate_pkg::addr_data);

  // steps through status0 then status1 on data reads
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_reg <= fdc_rate_pkg::res_idle;
    end else if (soft_reset || !result_phase) begin
      res_reg <= fdc_rate_pkg::res_idle;
    end else begin
      unique case (res_reg)
        fdc_rate_pkg::res_idle: begin
          res_reg <= fdc_rate_pkg::res_st0;
        end
        fdc_rate_pkg::res_st0: begin
          if (rd_data) begin
            res_reg <= fdc_rate_pkg::res_st1;
          end
        end
        fdc_rate_pkg::res_st1: begin
          // stays here; every later data read returns status1 again
          res_reg <= fdc_rate_pkg::res_st1;
        end
        default: begin
          res_reg <= fdc_rate_pkg::res_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux, one cycle latency
  // ----------------------------------------------------------------
  logic       disk_changed;
  logic [7:0] input_val;
  logic [7:0] input_oe;

  assign disk_changed = force_chg_en ? force_chg_val : ~chg_sync;

  always_comb begin
    input_val = fdc_rate_pkg::zero_byte;
    input_oe  = fdc_rate_pkg::oe_all;
    unique case (mode)
      fdc_rate_pkg::mode_std: begin
        input_oe = fdc_rate_pkg::oe_bit7;
        input_val[fdc_rate_pkg::bit_disk_changed] = disk_changed;
      end
      fdc_rate_pkg::mode_bidir: begin
        input_val = {disk_changed, fdc_rate_pkg::ones_nib,
                     rate_sel, ~high_rate(rate_sel)};
      end
      default: begin
        input_val = {disk_changed, fdc_rate_pkg::zero_tri,
                     dma_gate,
                     precomp_off,
                     rate_sel};
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata    <= fdc_rate_pkg::zero_byte;
      io_rdata_oe <= fdc_rate_pkg::zero_byte;
      io_rvalid   <= 1'b0;
    end else begin
      io_rvalid <= 1'b0;
      if (io_rd && io_addr == fdc_rate_pkg::addr_input) begin
        io_rdata    <= input_val;
        io_rdata_oe <= input_oe;
        io_rvalid   <= 1'b1;
      end else if (rd_data && res_reg != fdc_rate_pkg::res_idle) begin
        // first data read gives status0, every later one status1
        io_rdata    <= (res_reg == fdc_rate_pkg::res_st0) ? status0 : status1;
        io_rdata_oe <= fdc_rate_pkg::oe_all;
        io_rvalid   <= 1'b1;
      end else if (io_rd) begin
        // other addresses belong to neighbouring blocks
        io_rdata_oe <= fdc_rate_pkg::zero_byte;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/fdc_rate_pkg.sv
package fdc_rate_pkg;

  // ----------------------------------------------------------------
  // host i/o addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] addr_data  = 10'h3f5; // data register, result bytes
  localparam logic [9:0] addr_input = 10'h3f7; // input reg read, rate write

  // ----------------------------------------------------------------
  // field positions and fixed values
  // ----------------------------------------------------------------
  localparam int         bit_disk_changed  = 7;      // disk-changed flag position
  localparam int         bit_precomp = 2;      // precomp_off in rate write
  localparam logic [1:0] rate_250k   = 2'h0_2; // hardware reset rate
  localparam logic [1:0] rate_500k   = 2'h0_0;
  localparam logic [1:0] rate_1m     = 2'h0_3;
  localparam logic [7:0] zero_byte   = 8'h00;
  localparam logic [3:0] ones_nib    = 4'h0_f; // bits 3..6 in bidir mode
  localparam logic [2:0] zero_tri    = 3'h0_0; // bits 4..6 in compact mode
  localparam logic [7:0] oe_bit7     = 8'h80;  // standard mode drives bit 7 only
  localparam logic [7:0] oe_all      = 8'hff;
  localparam logic       density_rst = 1'b1;   // density pin after hw reset

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int recal_steps = 80;             // steps before track-0 check
  localparam int index_limit = 2;              // index pulses per id search

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_compact = 2'b00,
    mode_bidir   = 2'b01,
    mode_std     = 2'b10
  } reg_mode_e;

  typedef enum logic [1:0] {
    res_idle = 2'b00,
    res_st0  = 2'b01,
    res_st1  = 2'b11
  } res_state_e;

  // events reported by the command sequencer, one-cycle pulses
  typedef struct packed {
    logic       cmd_start;     // new command enters execution
    logic       cmd_done;      // command ends, intr_code valid
    logic [1:0] intr_code;     // completion code with cmd_done
    logic       seek_done;     // seek, relative seek or recalibrate done
    logic       step;          // one step pulse issued
    logic       outward_past0; // relative seek stepped below track 0
    logic       sector_over;   // access beyond last sector or no tc
    logic       crc_bad;       // crc mismatch in id or data field
    logic       service_late;  // overrun or underrun
    logic       no_sector;     // sector, id or sequence not found
    logic       no_data_mark;  // data address mark missing
  } seq_event_s;

  // command context levels from the sequencer
  typedef struct packed {
    logic       recal_active;  // recalibrate in progress
    logic       write_active;  // write, write deleted or format running
    logic       id_search;     // searching for an id address mark
    logic       side_number;   // current head
    logic [1:0] unit_select;   // current drive
  } seq_ctx_s;

endpackage

// File: dv/floppy_rate_chk.sv
`timescale 1ns/1ps
`default_nettype none
module floppy_rate_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // host i/o
  input wire logic [9:0] io_addr,
  input wire logic       io_rd,
  input wire logic       io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] io_rdata_oe,
  input wire logic       io_rvalid,
  // configuration and state
  input wire logic       cfg_ident,
  input wire logic       cfg_mfm,
  input wire logic       force_chg_en,
  input wire logic       force_chg_val,
  input wire logic       dma_gate,
  input wire logic       result_phase,
  input wire logic       density_select,
  input wire logic [1:0] rate_sel,
  input wire logic       precomp_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // helper terms
  // ------------------------------------------------------------
  wire logic       dir_rd   = io_rd && io_addr == fdc_rate_pkg::addr_input; // input register read
  wire logic       dir_wr   = io_wr && io_addr == fdc_rate_pkg::addr_input; // rate control write
  wire logic [1:0] wr_rate  = io_wdata[1:0];                                // rate field of a write
  wire logic       low_rate = rate_sel[1] ^ rate_sel[0];                    // 250k or 300k selected
  // density a write should leave
  wire logic       den_exp  = (wr_rate[1] ~^ wr_rate[0]) ~^ cfg_ident;
  // ------------------------------------------------------------
  // read sequences, one for each register mode and one for result reads
  // ------------------------------------------------------------
  sequence s_std_rd;
    dir_rd && cfg_ident;
  endsequence
  sequence s_bidir_rd;
    dir_rd && !cfg_ident && cfg_mfm;
  endsequence
  sequence s_cmp_rd;
    dir_rd && !cfg_ident && !cfg_mfm;
  endsequence
  sequence s_res_rd;
    io_rd && io_addr == fdc_rate_pkg::addr_data && result_phase;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_std_bit7_only: assert property (s_std_rd |=> io_rdata_oe == 8'h80)
    else $error("standard mode read drives more than bit 7");
  a_bidir_layout: assert property (s_bidir_rd |=> io_rdata[6:0] == {4'hf, $past(rate_sel), $past(low_rate)})
    else $error("bidirectional mode input register layout wrong");
  a_compact_layout: assert property (s_cmp_rd |=>
    io_rdata[6:0] == {3'h0, $past(dma_gate), $past(precomp_off), $past(rate_sel)})
    else $error("compact mode input register layout wrong");
  a_forced_change: assert property (dir_rd && force_chg_en |=> io_rdata[7] == $past(force_chg_val))
    else $error("forced disk change value not shown in bit 7");
  a_rate_load: assert property (dir_wr |=> rate_sel == $past(wr_rate))
    else $error("rate write did not load the rate selection");
  a_density_load: assert property (dir_wr |=> density_select == $past(den_exp))
    else $error("density pin wrong after rate write");
  a_state_hold: assert property (!io_wr |=> $stable(rate_sel) && $stable(density_select) &&
    $stable(precomp_off))
    else $error("rate state changed without a write");
  a_hw_reset_vals: assert property ($rose(nrst) |-> density_select && rate_sel == 2'h2 && !precomp_off)
    else $error("hardware reset values wrong");
  a_read_answer: assert property (dir_rd |=> io_rvalid && io_rdata_oe != 8'h00)
    else $error("input register read not answered");
  a_rvalid_cause: assert property (io_rvalid |-> $past(io_rd))
    else $error("read valid without a read");
  a_unmapped_quiet: assert property (io_rd && !dir_rd && io_addr != fdc_rate_pkg::addr_data |=>
    !io_rvalid && io_rdata_oe == 8'h00)
    else $error("unmapped read answered");
  a_status_bit3: assert property (s_res_rd |=> io_rvalid ##0 io_rdata[3] == 1'b0)
    else $error("status byte bit 3 not zero");
endmodule
bind floppy_rate_and_result_status floppy_rate_chk u_floppy_rate_chk (
  .clk, .nrst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_oe, .io_rvalid,
  .cfg_ident, .cfg_mfm, .force_chg_en, .force_chg_val, .dma_gate, .result_phase,
  .density_select, .rate_sel, .precomp_off
);
`default_nettype wire

// File: dv/floppy_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// cable side: one index pulse a turn, level pins follow the bench one edge late
module floppy_drive_model #(
  parameter int rev_cycles = 12 // turn shortened so id searches stay brief
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // bench controls
  input  wire logic chg_ctl,
  input  wire logic wp_ctl,
  input  wire logic track_zero_pin_ctl,
  // cable pins
  output logic      disk_changed_pin,
  output logic      track_zero_pin,
  output logic      index_pin,
  output logic      write_protect_pin
);
  int rev; // position within one turn
  // spindle and index pulse, free running as a real motor would
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rev       <= 0;
      index_pin <= 1'b0;
    end else begin
      rev       <= (rev == rev_cycles - 1) ? 0 : rev + 1;
      index_pin <= (rev == 0);
    end
  end
  // level pins
  always_ff @(posedge clk) begin
    disk_changed_pin  <= chg_ctl;
    track_zero_pin    <= track_zero_pin_ctl;
    write_protect_pin <= wp_ctl;
  end
endmodule
`default_nettype wire

// File: dv/floppy_rate_and_result_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module floppy_rate_and_result_status_tb_top;
  // ------------------------------------------------------------
  // design signals
  // ------------------------------------------------------------
  logic                     clk = 1'b0, nrst = 1'b0, soft_reset = 1'b0;
  logic [9:0]               io_addr = 10'h000;
  logic                     io_rd = 1'b0, io_wr = 1'b0, io_rvalid;
  logic [7:0]               io_wdata = 8'h00, io_rdata, io_rdata_oe;
  logic                     cfg_ident = 1'b1, cfg_mfm = 1'b0, force_chg_en = 1'b0, force_chg_val = 1'b0;
  logic                     dma_gate = 1'b0, result_phase = 1'b0;
  fdc_rate_pkg::seq_event_s seq_ev = '0, ev;
  fdc_rate_pkg::seq_ctx_s   seq_ctx = '0;
  logic                     chg_ctl = 1'b0, wp_ctl = 1'b0, track_zero_pin_ctl = 1'b1;
  logic                     disk_changed_pin, track_zero_pin, index_pin, write_protect_pin;
  logic                     density_select, precomp_off;
  logic [1:0]               rate_sel;
  // reference model state and bookkeeping
  int                       m_rate = 2, m_pre = 0, m_den = 1, bad_count = 0, cmp_count = 0;
  int                       q[$]; // expected result bytes in read order
  logic [7:0]               rnd = 8'h5b;

  always #10 clk = ~clk;

  // step_count cut to 4 so a recalibrate fault needs only 4 steps
  floppy_rate_and_result_status #(.step_count(4), .index_count(2)) u_floppy_rate_and_result_status (
    .clk, .nrst, .soft_reset, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_oe, .io_rvalid,
    .cfg_ident, .cfg_mfm, .force_chg_en, .force_chg_val, .dma_gate, .result_phase, .seq_ev, .seq_ctx,
    .disk_changed_pin, .track_zero_pin, .index_pin, .write_protect_pin, .density_select, .rate_sel,
    .precomp_off);
  floppy_drive_model u_floppy_drive_model (
    .clk, .nrst, .chg_ctl, .wp_ctl, .track_zero_pin_ctl, .disk_changed_pin, .track_zero_pin, .index_pin,
    .write_protect_pin);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d of %0d comparisons", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle host write strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  // one-cycle read strobe, bounded wait for the answer
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic [7:0] oe);
    int n;
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    for (n = 0; n < 4 && io_rvalid !== 1'b1; n++) @(negedge clk);
    if (n == 4) begin
      check("read answer", io_rvalid, 8'h01);
      end_sim();
    end
    d = io_rdata;
    oe = io_rdata_oe;
  endtask
  // sequencer event pulse lasting one cycle
  task automatic pulse(input fdc_rate_pkg::seq_event_s e);
    @(negedge clk);
    seq_ev = e;
    @(negedge clk);
    seq_ev = '0;
  endtask
  // expected input register: 0 compact, 1 bidirectional, 2 standard
  function automatic logic [7:0] exp_dir(input int m);
    int d, hi;
    d = force_chg_en ? force_chg_val : !chg_ctl;
    hi = (m_rate == 0 || m_rate == 3);
    if (m == 2) return d << 7;
    if (m == 1) return (d << 7) | 8'h78 | (m_rate << 1) | !hi;
    return (d << 7) | (dma_gate << 3) | (m_pre << 2) | m_rate;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d, oe;
    int m, r;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    cyc(3);
    check("rate after reset", rate_sel, 8'h02);
    check("density after reset", density_select, 8'h01);
    check("precomp after reset", precomp_off, 8'h00);
    // every rate in every mode, random change source and dma gate
    for (int i = 0; i < 36; i++) begin
      m = i % 3;
      r = (i / 3) % 4;
      rnd = lfsr(rnd);
      cfg_ident = (m == 2);
      cfg_mfm = (m == 1);
      {dma_gate, chg_ctl, force_chg_en, force_chg_val} = rnd[7:4];
      wr(fdc_rate_pkg::addr_input, (m == 0) ? {5'h00, rnd[2], 2'(r)} : {6'h00, 2'(r)});
      m_rate = r;
      if (m == 0) m_pre = rnd[2];
      m_den = ((r == 0 || r == 3) == (m == 2));
      cyc(3);
      rd(fdc_rate_pkg::addr_input, d, oe);
      check("input reg", d, exp_dir(m));
      check("input oe", oe, (m == 2) ? 8'h80 : 8'hff);
      check("rate_sel", rate_sel, m_rate);
      check("precomp_off", precomp_off, m_pre);
      check("density", density_select, m_den);
    end
    // software reset leaves rate, precomp and density alone
    cfg_ident = 1'b0;
    cfg_mfm = 1'b0;
    wr(fdc_rate_pkg::addr_input, 8'h05);
    m_rate = 1;
    m_pre = 1;
    m_den = 1;
    @(negedge clk);
    soft_reset = 1'b1;
    cyc(2);
    soft_reset = 1'b0;
    check("rate after soft reset", rate_sel, 8'h01);
    check("precomp after soft reset", precomp_off, 8'h01);
    check("density after soft reset", density_select, 8'h01);
    rd(fdc_rate_pkg::addr_input, d, oe);
    check("input reg after soft reset", d, exp_dir(0));
    // unmapped place and data register outside the result phase
    for (int a = 0; a < 2; a++) begin
      wr(a ? 10'h3f6 : fdc_rate_pkg::addr_data, 8'h02);
      @(negedge clk);
      io_addr = a ? 10'h3f6 : fdc_rate_pkg::addr_data;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      check("ignored read valid", io_rvalid, 8'h00);
      check("ignored read oe", io_rdata_oe, 8'h00);
      check("rate after foreign write", rate_sel, 8'h01);
    end
    // one command per completion code, each raising its own flags
    for (int k = 0; k < 4; k++) begin
      seq_ctx.side_number = k[0];
      seq_ctx.unit_select = 2'(3 - k);
      ev = '0;
      ev.cmd_start = 1'b1;
      pulse(ev);
      ev = '0;
      {ev.seek_done, ev.sector_over, ev.crc_bad} = {3{k == 0}};
      {ev.outward_past0, ev.service_late, ev.no_sector} = {3{k == 1}};
      ev.no_data_mark = (k == 2);
      pulse(ev);
      if (k == 2) begin
        wp_ctl = 1'b1;
        seq_ctx.write_active = 1'b1;
        cyc(6);
        wp_ctl = 1'b0;
        seq_ctx.write_active = 1'b0;
      end
      if (k == 3) begin
        track_zero_pin_ctl = 1'b0;
        seq_ctx.recal_active = 1'b1;
        ev = '0;
        ev.step = 1'b1;
        repeat (4) pulse(ev);
        seq_ctx.id_search = 1'b1;
        cyc(32);
        {seq_ctx.recal_active, seq_ctx.id_search, track_zero_pin_ctl} = 3'b001;
        cyc(3);
      end
      ev = '0;
      ev.cmd_done = 1'b1;
      ev.intr_code = 2'(k);
      pulse(ev);
      q.push_back(k * 64 + (k == 0) * 32 + (k[0] ? 16 : 0) + k[0] * 4 + 3 - k);
      q.push_back((k==0)*160 + (k==1)*20 + (k==2)*2 + (k>=2));
      q.push_back(q[1]);
      result_phase = 1'b1;
      cyc(2);
      repeat (3) begin
        rd(fdc_rate_pkg::addr_data, d, oe);
        check("status byte", d, 8'(q.pop_front()));
        check("status oe", oe, 8'hff);
      end
      result_phase = 1'b0;
    end
    end_sim();
  end
endmodule
`default_nettype wire
